// ### design/pal_access_lock.sv
`timescale 1ns/1ps
`include "pal_params.svh"
module pal_access_lock
   import pal_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic por_n,
   input wire logic running,
   input pal_wr_req_t wr_req,
   output pal_wr_resp_t wr_resp,
   output logic [1:0] access_level,
   output logic lock_flag,
   output logic perm_lock,
   output logic nv_write_en,
   output logic [`PAL_NPARAM-1:0] param_locked
);

   // =====================================================================
   // State and wires
   logic [1:0] level_reg;
   logic [1:0] level_next;
   logic tlock_reg;
   logic tlock_next;
   logic nven_reg;
   logic nven_next;
   logic flag_reg;
   logic flag_next;
   pal_wr_resp_t resp_reg;
   pal_wr_resp_t resp_next;
   logic [`PAL_NPARAM-1:0] locked_reg;
   logic [`PAL_NPARAM-1:0] locked_next;
   logic [`PAL_NPARAM-1:0] locked_now;
   logic run_s;
   logic [`PAL_NLEV-1:0][`PAL_CODE_W-1:0] codes;
   logic [`PAL_CODE_W-1:0] code1;
   logic [`PAL_CODE_W-1:0] code2;
   logic perm_q;
   logic code_we;
   logic perm_set;
   logic perm_clr;
   logic ok;
   logic hit1;
   logic hit2;

   assign code1 = codes[0];
   assign code2 = codes[1];

   // =====================================================================
   // Running status from the motor side
   pal_sync2 #(
      .W(1)
   ) u_run_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .d(running),
      .q(run_s)
   );

   // =====================================================================
   // Non-volatile codes and permanent lock
   pal_code_store #(
      .NLEV(`PAL_NLEV)
   ) u_codes (
      .mclk(mclk),
      .por_n(por_n),
      .code_we(code_we),
      .code_lvl(level_reg),
      .code_val(wr_req.data),
      .perm_set(perm_set),
      .perm_clr(perm_clr),
      .codes(codes),
      .perm_q(perm_q)
   );

   // =====================================================================
   // Blocked parameter classes for a given state
   function automatic logic [`PAL_NPARAM-1:0] blocked(
      input logic [1:0] lvl,
      input logic tl,
      input logic run
   );
      logic [`PAL_NPARAM-1:0] b;
      logic l0;
      b = '0;
      l0 = (lvl == `PAL_LVL0);
      b[PAL_P_LOCK] = l0;
      b[PAL_P_LEVEL] = 1'b0;
      b[PAL_P_NEWCODE] = l0 | tl;
      b[PAL_P_FACTORY] = (lvl != `PAL_LVL2) | tl | run;
      b[PAL_P_NVEN] = (lvl != `PAL_LVL2) | tl;
      b[PAL_P_STOPONLY] = l0 | tl | run;
      b[PAL_P_GENERAL] = l0 | tl;
      return b;
   endfunction : blocked

   assign locked_now = blocked(level_reg, tlock_reg, run_s);
   assign hit2 = (wr_req.data == code2);
   assign hit1 = (wr_req.data == code1);

   // =====================================================================
   // Next state of level, locks and write answer
   always_comb
   begin
      level_next = level_reg;
      tlock_next = tlock_reg;
      nven_next = nven_reg;
      resp_next = '0;
      code_we = 1'b0;
      perm_set = 1'b0;
      perm_clr = 1'b0;
      ok = 1'b0;
      if (!rst_n)
      begin
         level_next = perm_q ? `PAL_LVL0 : `PAL_LVL1;
         tlock_next = 1'b0;
         nven_next = `PAL_NVEN_RST;
      end
      else if (wr_req.valid)
      begin
         ok = !locked_now[wr_req.param];
         unique case (wr_req.param)
            PAL_P_LOCK:
            begin
               ok = ok && (wr_req.data == `PAL_YES ||
                  wr_req.data == `PAL_NO);
               if (ok && wr_req.data == `PAL_YES)
               begin
                  if (code1 == `PAL_CODE1_DEF)
                     tlock_next = 1'b1;
                  else
                  begin
                     level_next = `PAL_LVL0;
                     tlock_next = 1'b0;
                     perm_set = 1'b1;
                  end
               end
               else if (ok)
                  tlock_next = 1'b0;
            end
            PAL_P_LEVEL:
            begin
               if (hit2)
               begin
                  level_next = `PAL_LVL2;
                  perm_clr = 1'b1;
               end
               else if (hit1)
               begin
                  level_next = `PAL_LVL1;
                  perm_clr = 1'b1;
               end
            end
            PAL_P_NEWCODE:
            begin
               ok = ok && (wr_req.data <= `PAL_CODE_MAX);
               code_we = ok;
            end
            PAL_P_FACTORY:
               resp_next.factory_load = ok;
            PAL_P_NVEN:
            begin
               ok = ok && (wr_req.data == `PAL_YES ||
                  wr_req.data == `PAL_NO);
               if (ok)
                  nven_next = wr_req.data[0];
            end
            PAL_P_STOPONLY, PAL_P_GENERAL:
            begin
               resp_next.commit = ok;
               resp_next.commit_nv = ok && nven_reg;
            end
            default:
               ok = 1'b0;
         endcase
         resp_next.ack = ok;
         resp_next.rej = !ok;
      end
      flag_next = (level_next == `PAL_LVL0) | tlock_next;
      locked_next = blocked(level_next, tlock_next, run_s);
   end

   always_ff @(posedge mclk)
   begin
      level_reg <= level_next;
      tlock_reg <= tlock_next;
      nven_reg <= nven_next;
      flag_reg <= flag_next;
      resp_reg <= resp_next;
      locked_reg <= locked_next;
   end

   // =====================================================================
   // Outputs
   assign access_level = level_reg;
   assign lock_flag = flag_reg;
   assign perm_lock = perm_q;
   assign nv_write_en = nven_reg;
   assign wr_resp = resp_reg;
   assign param_locked = locked_reg;

   // =====================================================================
   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_lock_yes;
      wr_req.valid && wr_req.param == PAL_P_LOCK &&
         wr_req.data == `PAL_YES && level_reg != `PAL_LVL0;
   endsequence

   sequence s_level_entry;
      wr_req.valid && wr_req.param == PAL_P_LEVEL;
   endsequence

   a_level_legal: assert property (
      access_level != 2'h3)
      else $error("illegal access level");

   a_lvl0_rejects: assert property (
      wr_req.valid && level_reg == `PAL_LVL0 &&
         wr_req.param != PAL_P_LEVEL |=> wr_resp.rej && !wr_resp.commit)
      else $error("level 0 accepted a write");

   a_lvl0_flag: assert property (
      access_level == `PAL_LVL0 && $stable(access_level) |-> lock_flag)
      else $error("lock flag not YES at level 0");

   a_factory_gate: assert property (
      wr_req.valid && wr_req.param == PAL_P_FACTORY &&
         level_reg != `PAL_LVL2 |=> wr_resp.rej && !wr_resp.factory_load)
      else $error("factory load below level 2");

   a_nven_gate: assert property (
      wr_req.valid && wr_req.param == PAL_P_NVEN &&
         level_reg == `PAL_LVL1 |=> wr_resp.rej && $stable(nv_write_en))
      else $error("nv enable changed at level 1");

   a_level_switch: assert property (
      s_level_entry ##0 hit2 |=> access_level == `PAL_LVL2 && !perm_lock)
      else $error("code 2 did not select level 2");

   a_level_nomatch: assert property (
      s_level_entry ##0 !hit1 && !hit2 |=> $stable(access_level))
      else $error("level changed on unknown code");

   a_temp_lock: assert property (
      s_lock_yes ##0 code1 == `PAL_CODE1_DEF && !locked_now[PAL_P_LOCK]
         |=> lock_flag && $stable(access_level) ##1
         wr_resp.rej || !$past(wr_req.valid) ||
         $past(wr_req.param) == PAL_P_LOCK ||
         $past(wr_req.param) == PAL_P_LEVEL)
      else $error("temporary lock failed");

   a_perm_lock: assert property (
      s_lock_yes ##0 code1 != `PAL_CODE1_DEF
         |=> access_level == `PAL_LVL0 && perm_lock)
      else $error("permanent lock failed");

   a_unlock_no: assert property (
      wr_req.valid && wr_req.param == PAL_P_LOCK &&
         wr_req.data == `PAL_NO && level_reg != `PAL_LVL0
         |=> !lock_flag && wr_resp.ack)
      else $error("lock NO did not unlock");

   a_new_code: assert property (
      wr_req.valid && wr_req.param == PAL_P_NEWCODE &&
         level_reg == `PAL_LVL1 && !tlock_reg &&
         wr_req.data <= `PAL_CODE_MAX |=> code1 == $past(wr_req.data))
      else $error("level 1 code not replaced");

   a_stop_only: assert property (
      wr_req.valid && wr_req.param == PAL_P_STOPONLY && run_s
         |=> wr_resp.rej && !wr_resp.commit)
      else $error("stop-only write while running");

   a_nv_commit: assert property (
      wr_resp.commit_nv |-> wr_resp.commit && nv_write_en)
      else $error("nv commit without enable");

   a_perm_leave: assert property (
      s_level_entry ##0 hit1 && !hit2
         |=> access_level == `PAL_LVL1 && !perm_lock)
      else $error("code 1 did not leave the lock");

   a_no_lvl0_entry: assert property (
      s_level_entry |=> access_level != `PAL_LVL0 ||
         $past(access_level) == `PAL_LVL0)
      else $error("entry selected level 0");

   a_lvl0_padlock: assert property (
      access_level == `PAL_LVL0 |-> param_locked == 7'h7d)
      else $error("level 0 padlocks wrong");

   a_temp_padlock: assert property (
      lock_flag && access_level != `PAL_LVL0 |->
         param_locked[PAL_P_GENERAL] && !param_locked[PAL_P_LOCK])
      else $error("temporary lock padlocks wrong");

   a_reset_level: assert property (
      @(posedge mclk) disable iff (!por_n)
      !rst_n ##1 !rst_n ##1 rst_n |-> access_level ==
         (perm_lock ? `PAL_LVL0 : `PAL_LVL1) && !lock_flag == !perm_lock)
      else $error("wrong level after reset");

endmodule : pal_access_lock

// ### design/pal_params.svh
// Function
// - Exactly three access levels 0, 1, 2; one active at a time.
// - Level 0 rejects all edits; lock flag reads YES and is fixed.
// - Level 1 edits everything except factory load and NV write enable.
// - Only level 2 may load a factory parameter set.
// - Levels 1 and 2 each hold a code from 0 to 9999.
// - Confirmed entry value switches to the level owning that code.
// - Entry value matching no code leaves the level unchanged.
// - Default codes: 0 for level 1, 1 for level 2.
// - Reading the entry parameter returns the active level, not a code.
// - Reset without permanent lock makes level 1 active.
// - Lock YES with level-1 code zero: temporary lock, level kept.
// - Lock NO removes a temporary lock; editing per active level.
// - Reset clears a temporary lock.
// - Lock YES with nonzero level-1 code forces level 0: permanent lock.
// - Permanent lock survives rst_n reset, level 0 stays; por_n clears it.
// - Entering level 1 or 2 code leaves permanent lock.
// - Level-1 code back to zero makes later locks temporary.
// - New-code write replaces the active level's code.
// - Level 0 has no code; no entry selects it.
// - Stop-only parameters are refused while the converter runs.
// - Every write-blocked parameter class shows a lock indication.
// - NV write enable NO keeps changes volatile only.
`ifndef PAL_PARAMS_SVH
`define PAL_PARAMS_SVH

// =====================================================================
// Widths
`define PAL_CODE_W 14
`define PAL_NPARAM 7
`define PAL_NLEV 2

// =====================================================================
// Levels and values
`define PAL_LVL0 2'h0
`define PAL_LVL1 2'h1
`define PAL_LVL2 2'h2
`define PAL_CODE_MAX 14'h270f
`define PAL_CODE1_DEF 14'h0000
`define PAL_CODE2_DEF 14'h0001
`define PAL_YES 14'h0001
`define PAL_NO 14'h0000
`define PAL_NVEN_RST 1'b1

`endif

// ### design/pal_pkg.sv
package pal_pkg;

   // =====================================================================
   // Parameter classes seen by the access logic
   typedef enum logic [2:0] {
      PAL_P_LOCK,
      PAL_P_LEVEL,
      PAL_P_NEWCODE,
      PAL_P_FACTORY,
      PAL_P_NVEN,
      PAL_P_STOPONLY,
      PAL_P_GENERAL
   } pal_param_t;

   // Write request from panel or host
   typedef struct packed {
      logic valid;
      pal_param_t param;
      logic [13:0] data;
   } pal_wr_req_t;

   // Registered answer to a write
   typedef struct packed {
      logic ack;
      logic rej;
      logic commit;
      logic commit_nv;
      logic factory_load;
   } pal_wr_resp_t;

endpackage : pal_pkg

// ### design/pal_sync2.sv
`timescale 1ns/1ps
`include "pal_params.svh"
module pal_sync2
#(
   parameter int W = 1
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   // =====================================================================
   // Two-stage synchroniser
   always_comb
   begin
      meta_next = rst_n ? d : '0;
      q_next = rst_n ? meta_reg : '0;
   end

   always_ff @(posedge mclk)
   begin
      meta_reg <= meta_next;
      q_reg <= q_next;
   end

   assign q = q_reg;

endmodule : pal_sync2

// ### design/pal_code_store.sv
`timescale 1ns/1ps
`include "pal_params.svh"
module pal_code_store
   import pal_pkg::*;
#(
   parameter int NLEV = `PAL_NLEV
)
(
   input wire logic mclk,
   input wire logic por_n,
   input wire logic code_we,
   input wire logic [1:0] code_lvl,
   input wire logic [`PAL_CODE_W-1:0] code_val,
   input wire logic perm_set,
   input wire logic perm_clr,
   output logic [NLEV-1:0][`PAL_CODE_W-1:0] codes,
   output logic perm_q
);

   logic [NLEV-1:0][`PAL_CODE_W-1:0] code_reg;
   logic [NLEV-1:0][`PAL_CODE_W-1:0] code_next;
   logic perm_reg;
   logic perm_next;

   // =====================================================================
   // One code each for levels 1 and 2, kept through rst_n, only por_n restores
   genvar g;
   generate
      for (g = 0; g < NLEV; g++)
      begin : g_code
         always_comb
         begin
            if (!por_n)
               code_next[g] = (g == 0) ? `PAL_CODE1_DEF : `PAL_CODE2_DEF;
            else if (code_we && code_lvl == 2'(g + 1))
               code_next[g] = code_val;
            else
               code_next[g] = code_reg[g];
         end

         always_ff @(posedge mclk)
         begin
            code_reg[g] <= code_next[g];
         end
      end
   endgenerate

   // =====================================================================
   // Permanent lock marker, set wins over clear
   always_comb
   begin
      if (!por_n)
         perm_next = 1'b0;
      else if (perm_set)
         perm_next = 1'b1;
      else if (perm_clr)
         perm_next = 1'b0;
      else
         perm_next = perm_reg;
   end

   always_ff @(posedge mclk)
   begin
      perm_reg <= perm_next;
   end

   assign codes = code_reg;
   assign perm_q = perm_reg;

endmodule : pal_code_store

// ### verification/pal_panel.sv
`timescale 1ns/1ps
// =====================================================================
// Operator panel model: one write word per call, taken at next rise
module pal_panel
   import pal_pkg::*;
(
   input wire logic mclk,
   output pal_wr_req_t wr_req
);
   // Quiet panel at start
   initial
   begin
      wr_req = '0;
   end

   // Present a write now (at a falling edge), hold it over one rise
   task automatic put(input pal_param_t p, input logic [13:0] d);
      wr_req.valid = 1'b1;
      wr_req.param = p;
      wr_req.data = d;
      @(negedge mclk);
   endtask : put

   // Release: strobe low, data inverted so no stale word lingers
   task automatic idle();
      wr_req.valid = 1'b0;
      wr_req.data = ~wr_req.data;
      @(negedge mclk);
   endtask : idle
endmodule : pal_panel

// ### verification/pal_access_lock_bench.sv
`timescale 1ns/1ps
`include "pal_params.svh"
// =====================================================================
// Bench for the access lock block
module pal_access_lock_bench
   import pal_pkg::*;
();
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic running = 1'b0;
   pal_wr_req_t wr_req;
   pal_wr_resp_t wr_resp;
   logic [1:0] access_level;
   logic lock_flag, perm_lock, nv_write_en;
   logic [`PAL_NPARAM-1:0] param_locked;
   int n_fail = 0;
   int checked = 0;
   logic [31:0] seed = 32'h000176bc;
   logic [1:0] m_lvl;
   logic m_temp, m_perm, m_nven;
   logic [13:0] m_code [2];

   // Clock of 40 ns
   always #20 mclk = ~mclk;

   pal_panel panel (.mclk(mclk), .wr_req(wr_req));
   pal_access_lock uut (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
      .running(running), .wr_req(wr_req), .wr_resp(wr_resp),
      .access_level(access_level), .lock_flag(lock_flag),
      .perm_lock(perm_lock), .nv_write_en(nv_write_en),
      .param_locked(param_locked));

   // =====================================================================
   // Expectation helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic blk(input pal_param_t p, input logic run);
      if (m_lvl == `PAL_LVL0)
         return p != PAL_P_LEVEL;
      if (m_temp)
         return !(p == PAL_P_LOCK || p == PAL_P_LEVEL);
      if (p == PAL_P_FACTORY)
         return m_lvl != `PAL_LVL2 || run;
      if (p == PAL_P_NVEN)
         return m_lvl != `PAL_LVL2;
      return p == PAL_P_STOPONLY && run;
   endfunction : blk

   // =====================================================================
   // Compare tasks and verdict
   task automatic chk_resp(input pal_wr_resp_t got, input pal_wr_resp_t exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_resp

   task automatic chk_state(input logic run);
      logic [`PAL_NPARAM+4:0] e;
      logic [`PAL_NPARAM+4:0] g;
      e[`PAL_NPARAM+4:`PAL_NPARAM] = {m_lvl, m_lvl == `PAL_LVL0 || m_temp,
         m_perm, m_nven};
      for (int i = 0; i < `PAL_NPARAM; i++)
         e[i] = blk(pal_param_t'(i), run);
      g = {access_level, lock_flag, perm_lock, nv_write_en, param_locked};
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t state got=%h exp=%h", $time, g, e);
      end
   endtask : chk_state

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : final_report

   // =====================================================================
   // Stimulus tasks
   task automatic wr(input pal_param_t p, input logic [13:0] d);
      pal_wr_resp_t e;
      logic r;
      e = '0;
      r = blk(p, running) || (p == PAL_P_NEWCODE && d > `PAL_CODE_MAX) ||
         ((p == PAL_P_LOCK || p == PAL_P_NVEN) && d > `PAL_YES);
      panel.put(p, d);
      e.ack = !r;
      e.rej = r;
      if (!r)
         case (p)
            PAL_P_LOCK:
               if (d == `PAL_NO)
                  m_temp = 1'b0;
               else if (m_code[0] != 14'h0000)
               begin
                  m_lvl = `PAL_LVL0;
                  m_perm = 1'b1;
                  m_temp = 1'b0;
               end
               else
                  m_temp = 1'b1;
            PAL_P_LEVEL:
               if (d == m_code[1] || d == m_code[0])
               begin
                  m_lvl = (d == m_code[1]) ? `PAL_LVL2 : `PAL_LVL1;
                  m_perm = 1'b0;
               end
            PAL_P_NEWCODE: m_code[m_lvl - 2'h1] = d;
            PAL_P_FACTORY: e.factory_load = 1'b1;
            PAL_P_NVEN: m_nven = d[0];
            default:
            begin
               e.commit = 1'b1;
               e.commit_nv = m_nven;
            end
         endcase
      chk_resp(wr_resp, e);
      chk_state(running);
   endtask : wr

   task automatic do_reset(input logic por, input int n);
      rst_n = 1'b0;
      por_n = ~por;
      repeat (n) panel.idle();
      rst_n = 1'b1;
      por_n = 1'b1;
      if (por)
      begin
         m_code[0] = `PAL_CODE1_DEF;
         m_code[1] = `PAL_CODE2_DEF;
         m_perm = 1'b0;
      end
      m_lvl = m_perm ? `PAL_LVL0 : `PAL_LVL1;
      m_temp = 1'b0;
      m_nven = `PAL_NVEN_RST;
      chk_resp(wr_resp, '0);
      // Running sync reads 0 through reset, catches up 2 edges later, padlocks 3
      chk_state(1'b0);
      repeat (3) panel.idle();
      chk_state(running);
   endtask : do_reset

   task automatic set_run(input logic v);
      running = v;
      repeat (3) panel.idle();
   endtask : set_run

   // =====================================================================
   // Watchdog on the whole run
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      final_report();
   end

   // =====================================================================
   // Main sequence
   initial
   begin
      logic [31:0] r;
      @(negedge mclk);
      do_reset(1'b1, 12);
      wr(PAL_P_FACTORY, 14'h0000);
      wr(PAL_P_NVEN, 14'h0000);
      wr(PAL_P_GENERAL, 14'h0005);
      wr(PAL_P_LEVEL, 14'h0001);
      wr(PAL_P_FACTORY, 14'h0000);
      wr(PAL_P_NVEN, 14'h0002);
      wr(PAL_P_NVEN, 14'h0000);
      wr(PAL_P_GENERAL, 14'h0007);
      wr(PAL_P_LEVEL, 14'h0007);
      wr(PAL_P_NEWCODE, `PAL_CODE_MAX);
      wr(PAL_P_NEWCODE, 14'h2710);
      wr(PAL_P_LEVEL, 14'h0001);
      wr(PAL_P_LEVEL, 14'h0000);
      wr(PAL_P_LOCK, `PAL_YES);
      wr(PAL_P_GENERAL, 14'h0001);
      wr(PAL_P_LOCK, `PAL_NO);
      wr(PAL_P_LOCK, `PAL_YES);
      do_reset(1'b0, 2);
      set_run(1'b1);
      wr(PAL_P_STOPONLY, 14'h0003);
      wr(PAL_P_LEVEL, `PAL_CODE_MAX);
      wr(PAL_P_FACTORY, 14'h0000);
      set_run(1'b0);
      wr(PAL_P_STOPONLY, 14'h0003);
      wr(PAL_P_LEVEL, 14'h0000);
      wr(PAL_P_NEWCODE, 14'h0005);
      wr(PAL_P_LOCK, `PAL_YES);
      wr(PAL_P_LOCK, `PAL_NO);
      wr(PAL_P_NEWCODE, 14'h0000);
      wr(PAL_P_LEVEL, 14'h0000);
      do_reset(1'b0, 2);
      wr(PAL_P_LEVEL, 14'h0005);
      wr(PAL_P_NEWCODE, 14'h0000);
      wr(PAL_P_LOCK, `PAL_YES);
      wr(PAL_P_LOCK, `PAL_NO);
      // Random traffic, an idle gap before about half of the writes, else back to back
      for (int k = 0; k < 600; k++)
      begin
         r = xs();
         if (r[31:27] == 5'h00)
            set_run(r[26]);
         if (r[26:18] == 9'h000)
            do_reset(r[17], 2);
         if (r[5])
            panel.idle();
         wr(pal_param_t'(r[15:8] % 8'h07),
            r[7] ? {12'h000, r[1:0]} : r[29:16]);
      end
      set_run(1'b0);
      do_reset(1'b1, 2);
      wr(PAL_P_LEVEL, 14'h0001);
      panel.idle();
      final_report();
   end
endmodule : pal_access_lock_bench
